// File: design/slpwd_pkg.sv
// constants for the sleep and watchdog control block
package slpwd_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_WATCHDOG_CONTROL = 4'h4;
    localparam logic [3:0] OFF_POWER_CONTROL_FLAGS = 4'h8;
    localparam logic [3:0] OFF_CONFIG = 4'hc;
    // field positions
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam int POWER_CONTROL_FLAGS_WATCHDOG_RESET_CAUSE_FLAG_N_BIT = 4;
    localparam int WDT_PS_LSB = 1;
    localparam int WDT_SWEN_BIT = 0;
    // values after reset
    localparam logic [4:0] PS_RESET = 5'h0b;
    localparam logic SWEN_RESET = 1'h0;
    localparam logic [1:0] MODE_RESET = 2'h3;
    // period select limits: code 0 is 1:32, last valid code 2^23
    localparam logic [4:0] PS_MAX = 5'h12;
    localparam int PRESCALE_BASE_LOG2 = 5;
    localparam int WDT_CNT_W = 24;
    // watchdog mode configuration codes
    localparam logic [1:0] MODE_ALWAYS = 2'h3;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_SOFT = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    // timer1 clock source code that stops in sleep
    localparam logic [1:0] T1_SRC_SYSCLK = 2'h0;
    // timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int LF_FREQ_HZ = 31_000;
    localparam int LF_DIV_CYCLES = CLK_FREQ_HZ / LF_FREQ_HZ;
    localparam int LF_DIV_W = 12;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_ASLEEP,
        ST_OST_WAIT
    } slpwd_state_e;
endpackage : slpwd_pkg

// File: design/slpwd_sleep_and_watchdog_control.sv
// sleep sequencing and watchdog timer with an AXI4-Lite register slave
`timescale 1ns/10ps
// How it works
// - sleep entry clears watchdog, may keep counting
// - sleep entry clears power-down, sets timeout, stops cpu
// - low-frequency oscillator keeps running in sleep
// - timer1 and converter keep running on own clocks
// - io ports hold their state during sleep
// - other resets behave same asleep or awake
// - five wake events, three reset, two resume
// - sleep instruction prefetches next address
// - interrupt wakes if enabled, regardless of global enable
// - resume next instruction, then vector if enabled
// - every wake clears the watchdog
// - pending interrupt with global off makes sleep nop
// - interrupt during sleep completes sleep, wakes at once
// - watchdog expiry without clear resets device
// - watchdog ticks from low-frequency oscillator
// - two-bit mode config selects watchdog activity
// - period selectable, two seconds after any reset
// - watchdog cleared on listed conditions
// - expiry in sleep wakes, updates flags, no reset
// - crystal clock holds watchdog clear until start-up done
// - oscillator divider change leaves watchdog alone
// - five-bit period code, 1:32 doubling, over-range minimum
module slpwd_sleep_and_watchdog_control #(
    parameter int ADDR_W = 4,
    parameter int NUM_IRQ = 8,
    parameter int LF_DIV = slpwd_pkg::LF_DIV_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // core instruction strobes and state
    input wire logic sleepInstr,
    input wire logic watchdogClearInstr,
    input wire logic globalInterruptEnable,
    // interrupt flags and enables
    input wire logic [NUM_IRQ-1:0] irqFlags,
    input wire logic [NUM_IRQ-1:0] irqEnables,
    // reset sources
    input wire logic externalResetPin,
    input wire logic brownoutReset,
    input wire logic powerOnReset,
    // oscillator status
    input wire logic oscFail,
    input wire logic oscStartupTimerRunning,
    input wire logic sysClockIsCrystal,
    input wire logic [1:0] timer1ClockSource,
    input wire logic converterDedicatedOsc,
    // power and wake controls
    output logic cpuClockEnable,
    output logic lowFreqOscEnable,
    output logic timer1RunEnable,
    output logic converterRunEnable,
    output logic ioHoldEnable,
    output logic prefetchNext,
    output logic wakeResume,
    output logic isrVector,
    output logic deviceReset,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    typedef struct packed {
        slpwd_pkg::slpwd_state_e state;
        logic [slpwd_pkg::LF_DIV_W-1:0] lfDiv;
        logic [slpwd_pkg::WDT_CNT_W-1:0] wdtCount;
        logic [4:0] periodSelect;
        logic swen;
        logic [1:0] modeConfig;
        logic timeoutFlagN;
        logic powerDownFlagN;
        logic wdtResetCauseN;
        logic wakeByIrq;
        logic cpuClk;
        logic lfOsc;
        logic t1Run;
        logic convRun;
        logic ioHold;
        logic prefetch;
        logic resume;
        logic vector;
        logic devReset;
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } slpwd_regs_s;

    slpwd_regs_s r;
    slpwd_regs_s next_r;

    logic intPending;
    logic resetEvent;
    logic lfTick;
    logic asleep;
    logic wdtActive;
    logic wdtExpire;
    logic wdtClear;
    logic [slpwd_pkg::WDT_CNT_W-1:0] wdtLimit;
    logic [ADDR_W-1:0] wAddr;
    logic [ADDR_W-1:0] rAddr;

    // wake-capable interrupt and reset source decode
    assign intPending = |(irqFlags & irqEnables);
    assign resetEvent = externalResetPin | brownoutReset | powerOnReset;
    assign asleep = (r.state != slpwd_pkg::ST_AWAKE);
    assign wAddr = awaddr;
    assign rAddr = araddr;

    // low-frequency oscillator tick, free-running in every state
    // one pulse every LF_DIV clocks, never gated by the cpu clock
    assign lfTick = (r.lfDiv == slpwd_pkg::LF_DIV_W'(LF_DIV - 1));

    // watchdog activity per mode
    always_comb begin
        case (r.modeConfig)
            slpwd_pkg::MODE_ALWAYS: wdtActive = 1'b1;
            slpwd_pkg::MODE_AWAKE: wdtActive = (r.state == slpwd_pkg::ST_AWAKE);
            slpwd_pkg::MODE_SOFT: wdtActive = r.swen;
            default: wdtActive = 1'b0;
        endcase
    end

    // terminal count from the period code, over-range gives the minimum
    always_comb begin
        if (r.periodSelect > slpwd_pkg::PS_MAX) begin
            wdtLimit = slpwd_pkg::WDT_CNT_W'(1) << slpwd_pkg::PRESCALE_BASE_LOG2;
        end else begin
            wdtLimit = slpwd_pkg::WDT_CNT_W'(1)
                << (slpwd_pkg::PRESCALE_BASE_LOG2 + int'(r.periodSelect));
        end
    end

    assign wdtExpire = wdtActive && lfTick && (r.wdtCount == wdtLimit - 1'b1);

    // next state: bus slave first, hardware events after so they win
    always_comb begin
        next_r = r;
        wdtClear = 1'b0;
        next_r.prefetch = 1'b0;
        next_r.resume = 1'b0;
        next_r.vector = 1'b0;
        next_r.devReset = 1'b0;
        next_r.awready = 1'b0;
        next_r.wready = 1'b0;
        next_r.arready = 1'b0;
        next_r.lfOsc = 1'b1;

        // low-frequency divider, independent of the cpu clock gate
        if (r.lfDiv == LF_DIV[slpwd_pkg::LF_DIV_W-1:0] - 1'b1) begin
            next_r.lfDiv = '0;
        end else begin
            next_r.lfDiv = r.lfDiv + 1'b1;
        end

        // write channel: address and data taken in the same cycle
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        if (awvalid && wvalid && !r.awready && !r.bvalid) begin
            next_r.awready = 1'b1;
            next_r.wready = 1'b1;
            next_r.bvalid = 1'b1;
            next_r.bresp = slpwd_pkg::RESP_OKAY;
            case (wAddr)
                slpwd_pkg::OFF_STATUS: ; // flags are read-only
                slpwd_pkg::OFF_WATCHDOG_CONTROL: begin
                    if (wstrb[0]) begin
                        next_r.periodSelect = wdata[slpwd_pkg::WDT_PS_LSB+:5];
                        next_r.swen = wdata[slpwd_pkg::WDT_SWEN_BIT];
                    end
                end
                slpwd_pkg::OFF_POWER_CONTROL_FLAGS: begin
                    if (wstrb[0]) begin
                        next_r.wdtResetCauseN = wdata[slpwd_pkg::POWER_CONTROL_FLAGS_WATCHDOG_RESET_CAUSE_FLAG_N_BIT];
                    end
                end
                slpwd_pkg::OFF_CONFIG: begin
                    if (wstrb[0]) begin
                        next_r.modeConfig = wdata[1:0];
                    end
                end
                default: next_r.bresp = slpwd_pkg::RESP_SLVERR;
            endcase
        end

        // read channel
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (arvalid && !r.arready && !r.rvalid) begin
            next_r.arready = 1'b1;
            next_r.rvalid = 1'b1;
            next_r.rresp = slpwd_pkg::RESP_OKAY;
            next_r.rdata = '0;
            case (rAddr)
                slpwd_pkg::OFF_STATUS: begin
                    next_r.rdata[slpwd_pkg::STATUS_TO_BIT] = r.timeoutFlagN;
                    next_r.rdata[slpwd_pkg::STATUS_PD_BIT] = r.powerDownFlagN;
                end
                slpwd_pkg::OFF_WATCHDOG_CONTROL: begin
                    next_r.rdata[slpwd_pkg::WDT_PS_LSB+:5] = r.periodSelect;
                    next_r.rdata[slpwd_pkg::WDT_SWEN_BIT] = r.swen;
                end
                slpwd_pkg::OFF_POWER_CONTROL_FLAGS: next_r.rdata[slpwd_pkg::POWER_CONTROL_FLAGS_WATCHDOG_RESET_CAUSE_FLAG_N_BIT] = r.wdtResetCauseN;
                slpwd_pkg::OFF_CONFIG: next_r.rdata[1:0] = r.modeConfig;
                default: next_r.rresp = slpwd_pkg::RESP_SLVERR;
            endcase
        end

        // watchdog counts low-frequency ticks while active
        if (wdtActive && lfTick) begin
            next_r.wdtCount = r.wdtCount + 1'b1;
        end
        if (wdtExpire) begin
            next_r.wdtCount = '0;
        end

        // sleep sequencer
        case (r.state)
            slpwd_pkg::ST_AWAKE: begin
                if (sleepInstr) begin
                    next_r.prefetch = 1'b1;
                    if (!(intPending && !globalInterruptEnable)) begin
                        next_r.state = slpwd_pkg::ST_ASLEEP;
                        wdtClear = 1'b1;
                        next_r.powerDownFlagN = 1'b0;
                        next_r.timeoutFlagN = 1'b1;
                        next_r.cpuClk = 1'b0;
                        next_r.ioHold = 1'b1;
                        next_r.t1Run = (timer1ClockSource != slpwd_pkg::T1_SRC_SYSCLK);
                        next_r.convRun = converterDedicatedOsc;
                    end
                end else if (watchdogClearInstr) begin
                    wdtClear = 1'b1;
                    next_r.timeoutFlagN = 1'b1;
                    next_r.powerDownFlagN = 1'b1;
                end else if (wdtExpire) begin
                    next_r.devReset = 1'b1;
                    next_r.timeoutFlagN = 1'b0;
                    next_r.wdtResetCauseN = 1'b0;
                    next_r.periodSelect = slpwd_pkg::PS_RESET;
                    next_r.swen = slpwd_pkg::SWEN_RESET;
                end
            end
            slpwd_pkg::ST_ASLEEP: begin
                if (intPending || wdtExpire) begin
                    wdtClear = 1'b1;
                    next_r.wakeByIrq = intPending;
                    if (!intPending) begin
                        next_r.timeoutFlagN = 1'b0;
                        next_r.powerDownFlagN = 1'b0;
                        next_r.wdtResetCauseN = 1'b0;
                    end
                    if (sysClockIsCrystal) begin
                        next_r.state = slpwd_pkg::ST_OST_WAIT;
                    end else begin
                        next_r.state = slpwd_pkg::ST_AWAKE;
                        next_r.cpuClk = 1'b1;
                        next_r.ioHold = 1'b0;
                        next_r.t1Run = 1'b1;
                        next_r.convRun = 1'b1;
                        next_r.resume = 1'b1;
                        next_r.vector = intPending && globalInterruptEnable;
                    end
                end
            end
            slpwd_pkg::ST_OST_WAIT: begin
                wdtClear = 1'b1;
                if (!oscStartupTimerRunning) begin
                    next_r.state = slpwd_pkg::ST_AWAKE;
                    next_r.cpuClk = 1'b1;
                    next_r.ioHold = 1'b0;
                    next_r.t1Run = 1'b1;
                    next_r.convRun = 1'b1;
                    next_r.resume = 1'b1;
                    next_r.vector = r.wakeByIrq && globalInterruptEnable;
                end
            end
            default: next_r.state = slpwd_pkg::ST_AWAKE;
        endcase

        // other watchdog clearing conditions
        if (oscFail || oscStartupTimerRunning || !wdtActive) begin
            wdtClear = 1'b1;
        end
        if (wdtClear) begin
            next_r.wdtCount = '0;
        end

        // external, brown-out and power-on resets act the same in any state
        if (resetEvent) begin
            next_r.devReset = 1'b1;
            next_r.state = slpwd_pkg::ST_AWAKE;
            next_r.wdtCount = '0;
            next_r.periodSelect = slpwd_pkg::PS_RESET;
            next_r.swen = slpwd_pkg::SWEN_RESET;
            next_r.cpuClk = 1'b1;
            next_r.ioHold = 1'b0;
            next_r.t1Run = 1'b1;
            next_r.convRun = 1'b1;
            next_r.resume = 1'b0;
            next_r.vector = 1'b0;
            next_r.timeoutFlagN = 1'b1;
            next_r.powerDownFlagN = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.state <= slpwd_pkg::ST_AWAKE;
            r.periodSelect <= slpwd_pkg::PS_RESET;
            r.swen <= slpwd_pkg::SWEN_RESET;
            r.modeConfig <= slpwd_pkg::MODE_RESET;
            r.timeoutFlagN <= 1'b1;
            r.powerDownFlagN <= 1'b1;
            r.wdtResetCauseN <= 1'b1;
            r.cpuClk <= 1'b1;
            r.lfOsc <= 1'b1;
            r.t1Run <= 1'b1;
            r.convRun <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign cpuClockEnable = r.cpuClk;
    assign lowFreqOscEnable = r.lfOsc;
    assign timer1RunEnable = r.t1Run;
    assign converterRunEnable = r.convRun;
    assign ioHoldEnable = r.ioHold;
    assign prefetchNext = r.prefetch;
    assign wakeResume = r.resume;
    assign isrVector = r.vector;
    assign deviceReset = r.devReset;
    assign awready = r.awready;
    assign wready = r.wready;
    assign bresp = r.bresp;
    assign bvalid = r.bvalid;
    assign arready = r.arready;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rvalid;

endmodule : slpwd_sleep_and_watchdog_control

// File: testbench/slpwd_monitor.sv
// assertion checker for the sleep and watchdog control block
`timescale 1ns/10ps
module slpwd_monitor #(
    parameter int NUM_IRQ = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // core and wake inputs
    input wire logic sleepInstr,
    input wire logic globalInterruptEnable,
    input wire logic [NUM_IRQ-1:0] irqFlags,
    input wire logic [NUM_IRQ-1:0] irqEnables,
    input wire logic externalResetPin,
    input wire logic brownoutReset,
    input wire logic powerOnReset,
    input wire logic sysClockIsCrystal,
    input wire logic [1:0] timer1ClockSource,
    // power and wake outputs
    input wire logic cpuClockEnable,
    input wire logic lowFreqOscEnable,
    input wire logic timer1RunEnable,
    input wire logic ioHoldEnable,
    input wire logic prefetchNext,
    input wire logic wakeResume,
    input wire logic isrVector,
    input wire logic deviceReset
);
    // any enabled interrupt flagged
    wire logic pending = |(irqFlags & irqEnables);
    wire logic anyReset = externalResetPin || brownoutReset || powerOnReset;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // sleep entry, wake and reset relations
    chk_sleep_entry: assert property (cpuClockEnable && sleepInstr && !pending
        && !anyReset |=> !cpuClockEnable && ioHoldEnable) else $error("sleep entry wrong");
    chk_sleep_prefetch: assert property (cpuClockEnable && sleepInstr |=> prefetchNext)
        else $error("no prefetch");
    chk_nop_sleep: assert property (cpuClockEnable && sleepInstr && pending
        && !globalInterruptEnable |=> cpuClockEnable) else $error("sleep not a nop");
    chk_hold_level: assert property (ioHoldEnable != cpuClockEnable)
        else $error("io hold mismatch");
    chk_lf_running: assert property (lowFreqOscEnable)
        else $error("lf osc stopped");
    chk_irq_wake: assert property (!cpuClockEnable && pending && !sysClockIsCrystal
        |=> wakeResume) else $error("no irq wake");
    chk_vector_pair: assert property (isrVector |-> wakeResume)
        else $error("vector without resume");
    chk_timer1_run: assert property (!cpuClockEnable && $stable(timer1ClockSource)
        && timer1ClockSource != slpwd_pkg::T1_SRC_SYSCLK |-> timer1RunEnable)
        else $error("timer1 stopped");
    chk_reset_src: assert property (anyReset |=> deviceReset)
        else $error("reset source lost");
    chk_quiet_sleep: assert property (!cpuClockEnable && !anyReset |=> !deviceReset)
        else $error("reset from sleep");
    // main scenarios
    cov_sleep: cover property (cpuClockEnable && sleepInstr && !pending);
    cov_vector: cover property (wakeResume && isrVector);
    cov_reset: cover property (deviceReset);
    cov_nop: cover property (cpuClockEnable && sleepInstr && pending);
endmodule : slpwd_monitor

bind slpwd_sleep_and_watchdog_control slpwd_monitor #(.NUM_IRQ(NUM_IRQ)) slpwd_monitor_inst (
    .clk, .reset_n, .sleepInstr, .globalInterruptEnable, .irqFlags, .irqEnables,
    .externalResetPin, .brownoutReset, .powerOnReset, .sysClockIsCrystal,
    .timer1ClockSource, .cpuClockEnable, .lowFreqOscEnable, .timer1RunEnable,
    .ioHoldEnable, .prefetchNext, .wakeResume, .isrVector, .deviceReset);

// File: testbench/slpwd_core_model.sv
// behavioural processor core issuing sleep and watchdog clear strobes
`timescale 1ns/10ps
module slpwd_core_model (
    // clock
    input wire logic clk,
    // core clock gate from the block
    input wire logic cpuClockEnable,
    // instruction strobes
    output logic sleepInstr,
    output logic watchdogClearInstr
);
    // strobes idle low from time zero
    initial begin
        sleepInstr = 1'b0;
        watchdogClearInstr = 1'b0;
    end
    // one-cycle strobe, only while the core clock runs
    task automatic issue(input logic isSleep);
        @(posedge clk);
        while (cpuClockEnable !== 1'b1) @(posedge clk);
        if (isSleep) sleepInstr <= 1'b1;
        else watchdogClearInstr <= 1'b1;
        @(posedge clk);
        sleepInstr <= 1'b0;
        watchdogClearInstr <= 1'b0;
    endtask : issue
endmodule : slpwd_core_model

// File: testbench/sleep_and_watchdog_control_tb.sv
// self-checking bench for the sleep and watchdog control block
`timescale 1ns/10ps
module sleep_and_watchdog_control_tb;
    logic clk, reset_n, globalInterruptEnable, externalResetPin, brownoutReset, powerOnReset;
    logic oscFail, oscStartupTimerRunning, sysClockIsCrystal, converterDedicatedOsc;
    logic [7:0] irqFlags, irqEnables;
    logic [1:0] timer1ClockSource, bresp, rresp, rsp;
    logic sleepInstr, watchdogClearInstr, cpuClockEnable, lowFreqOscEnable, timer1RunEnable;
    logic converterRunEnable, ioHoldEnable, prefetchNext, wakeResume, isrVector, deviceReset;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    int mismatches, checked, resets, wakes, vectors, prefetches, r0, w0, v0, p0;

    // device with a short low-frequency divider
    slpwd_sleep_and_watchdog_control #(.LF_DIV(4)) slpwd_sleep_and_watchdog_control_inst (
        .clk, .reset_n, .sleepInstr, .watchdogClearInstr, .globalInterruptEnable, .irqFlags,
        .irqEnables, .externalResetPin, .brownoutReset, .powerOnReset, .oscFail,
        .oscStartupTimerRunning, .sysClockIsCrystal, .timer1ClockSource, .converterDedicatedOsc,
        .cpuClockEnable, .lowFreqOscEnable, .timer1RunEnable, .converterRunEnable,
        .ioHoldEnable, .prefetchNext, .wakeResume, .isrVector, .deviceReset, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    slpwd_core_model slpwd_core_model_inst (
        .clk, .cpuClockEnable, .sleepInstr, .watchdogClearInstr);

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // event counters for the one-cycle pulses
    always @(posedge clk) begin
        resets += (deviceReset === 1'b1);
        wakes += (wakeResume === 1'b1);
        vectors += (isrVector === 1'b1);
        prefetches += (prefetchNext === 1'b1);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // axi4-lite write, both channels offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge clk);
        while (awready !== 1'b1) @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        @(posedge clk);
        while (bvalid !== 1'b1) @(posedge clk);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr
    // axi4-lite read into rd and rsp
    task automatic rdreg(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clk);
        while (arready !== 1'b1) @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge clk);
        while (rvalid !== 1'b1) @(posedge clk);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rdreg
    task automatic report_and_stop;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    // test sequence
    initial begin
        {reset_n, globalInterruptEnable, externalResetPin, brownoutReset, powerOnReset} = 5'h0;
        {oscFail, oscStartupTimerRunning, sysClockIsCrystal, converterDedicatedOsc} = 4'h0;
        {irqFlags, irqEnables, timer1ClockSource, awaddr, araddr} = 26'h0;
        {awvalid, wvalid, bready, arvalid, rready, wdata} = 37'h0;
        wstrb = 4'hf;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdreg(slpwd_pkg::OFF_WATCHDOG_CONTROL);
        check(rd, 32'h16);
        rdreg(slpwd_pkg::OFF_CONFIG);
        check(rd, 32'h3);
        rdreg(4'h2);
        check({rd[29:0], rsp}, 32'h2);
        wr(4'h2, 32'h0);
        check({30'h0, rsp}, 32'h2);
        slpwd_core_model_inst.issue(1'b0);
        wr(slpwd_pkg::OFF_STATUS, 32'h0);
        rdreg(slpwd_pkg::OFF_STATUS);
        check(rd, 32'h18);
        // awake expiry at the shortest period
        wr(slpwd_pkg::OFF_WATCHDOG_CONTROL, 32'h0);
        r0 = resets;
        idle(100);
        check(resets - r0, 0);
        idle(60);
        check(resets - r0, 1);
        rdreg(slpwd_pkg::OFF_WATCHDOG_CONTROL);
        check(rd, 32'h16);
        // periodic clears hold off expiry
        wr(slpwd_pkg::OFF_WATCHDOG_CONTROL, 32'h0);
        r0 = resets;
        repeat (5) begin
            idle(60);
            slpwd_core_model_inst.issue(1'b0);
        end
        check(resets - r0, 0);
        // arm the reset-cause flag; a write with no byte strobe is ignored
        wr(slpwd_pkg::OFF_POWER_CONTROL_FLAGS, 32'h10);
        wstrb <= 4'h0;
        wr(slpwd_pkg::OFF_POWER_CONTROL_FLAGS, 32'h0);
        wstrb <= 4'hf;
        rdreg(slpwd_pkg::OFF_POWER_CONTROL_FLAGS);
        check(rd, 32'h10);
        // sleep in always-on mode, watchdog wakes without reset
        converterDedicatedOsc <= 1'b1;
        timer1ClockSource <= 2'h1;
        p0 = prefetches;
        slpwd_core_model_inst.issue(1'b1);
        w0 = wakes;
        idle(2);
        check({cpuClockEnable, ioHoldEnable, lowFreqOscEnable, timer1RunEnable,
            converterRunEnable}, 32'hf);
        check(prefetches - p0, 1);
        rdreg(slpwd_pkg::OFF_STATUS);
        check(rd, 32'h10);
        idle(90);
        check(wakes - w0, 0);
        idle(60);
        check(wakes - w0, 1);
        check(resets - r0, 0);
        rdreg(slpwd_pkg::OFF_POWER_CONTROL_FLAGS);
        check(rd & 32'h10, 32'h0);
        idle(60);
        check(resets - r0, 0);
        slpwd_core_model_inst.issue(1'b0);
        // off-in-sleep mode, then wake by enabled interrupt only
        wr(slpwd_pkg::OFF_CONFIG, 32'h2);
        slpwd_core_model_inst.issue(1'b1);
        w0 = wakes;
        v0 = vectors;
        idle(300);
        check(wakes - w0, 0);
        irqFlags <= 8'h04;
        idle(5);
        check(wakes - w0, 0);
        irqEnables <= 8'h04;
        idle(3);
        check(wakes - w0, 1);
        check(vectors - v0, 0);
        irqFlags <= 8'h00;
        slpwd_core_model_inst.issue(1'b0);
        // interrupt during sleep with global enable set
        globalInterruptEnable <= 1'b1;
        slpwd_core_model_inst.issue(1'b1);
        irqFlags <= 8'h80;
        irqEnables <= 8'h80;
        idle(3);
        check(wakes - w0, 2);
        check(vectors - v0, 1);
        irqFlags <= 8'h00;
        globalInterruptEnable <= 1'b0;
        rdreg(slpwd_pkg::OFF_STATUS);
        check(rd, 32'h10);
        // pending interrupt turns sleep into a nop
        slpwd_core_model_inst.issue(1'b0);
        p0 = prefetches;
        irqFlags <= 8'h01;
        irqEnables <= 8'h01;
        slpwd_core_model_inst.issue(1'b1);
        idle(2);
        check({31'h0, cpuClockEnable}, 32'h1);
        check(prefetches - p0, 1);
        rdreg(slpwd_pkg::OFF_STATUS);
        check(rd, 32'h18);
        irqFlags <= 8'h00;
        // each reset source, the first while asleep
        slpwd_core_model_inst.issue(1'b1);
        r0 = resets;
        for (int i = 0; i < 3; i++) begin
            externalResetPin <= (i == 0);
            brownoutReset <= (i == 1);
            powerOnReset <= (i == 2);
            @(posedge clk);
            {powerOnReset, brownoutReset, externalResetPin} <= 3'h0;
            idle(3);
            check(resets - r0, i + 1);
        end
        // disabled and software-controlled modes
        wr(slpwd_pkg::OFF_CONFIG, 32'h0);
        wr(slpwd_pkg::OFF_WATCHDOG_CONTROL, 32'h0);
        r0 = resets;
        idle(300);
        check(resets - r0, 0);
        wr(slpwd_pkg::OFF_CONFIG, 32'h1);
        wr(slpwd_pkg::OFF_WATCHDOG_CONTROL, 32'h1);
        idle(200);
        check(resets - r0, 1);
        // oscillator fail and start-up timer hold the watchdog clear
        wr(slpwd_pkg::OFF_CONFIG, 32'h3);
        wr(slpwd_pkg::OFF_WATCHDOG_CONTROL, 32'h0);
        oscFail <= 1'b1;
        r0 = resets;
        idle(200);
        check(resets - r0, 0);
        oscFail <= 1'b0;
        oscStartupTimerRunning <= 1'b1;
        sysClockIsCrystal <= 1'b1;
        slpwd_core_model_inst.issue(1'b1);
        w0 = wakes;
        idle(200);
        check(wakes - w0, 0);
        // crystal clock: interrupt wake waits for the start-up timer
        irqFlags <= 8'h02;
        irqEnables <= 8'h02;
        idle(20);
        check(wakes - w0, 0);
        check({31'h0, cpuClockEnable}, 32'h0);
        oscStartupTimerRunning <= 1'b0;
        idle(3);
        check(wakes - w0, 1);
        report_and_stop();
    end
endmodule : sleep_and_watchdog_control_tb
